// *** rtl/crcc_top.sv ***
/*
 crc control/status block with apb slave, input fifo and interrupt.
 assumes idle_mode_in is an asynchronous level from the power manager.
*/
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module crcc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        idle_mode_in,
    output logic             irq
);
    crcc_shift_if sif ();
    crcc_shifter u_shift (.pclk(pclk), .presetn(presetn), .sif(sif));

    logic [15:0] mem_q [16];
    logic [15:0] mem_d [16];
    logic [3:0]  rd_q, rd_d, wr_q, wr_d;
    logic [4:0]  valid_word_count_q, valid_word_count_d;
    logic [3:0]  poly_length_minus_one_q, poly_length_minus_one_d;
    logic        idle_halt_select_q, idle_halt_select_d;
    logic        shifter_launch_q, shifter_launch_d;
    logic [2:0]  st_q, st_d, mk_q, mk_d;
    logic [2:0]  idle_sync_q;
    logic [31:0] prdata_d;
    logic        pslverr_d, irq_d, pready_d;
    logic        idle_now, run, wr_acc, rd_acc, push, pop, fifo_full, fifo_empty;
    logic [4:0]  depth;
    logic        setup;
    logic        idle_stable_q, idle_stable_d;

    function automatic logic [4:0] crcc_depth(input logic [3:0] plen);
        crcc_depth = (plen > crcc_pkg::CRCC_WIDE_PLEN) ? crcc_pkg::CRCC_DEPTH_WIDE
                                                       : crcc_pkg::CRCC_DEPTH_NARR;
    endfunction : crcc_depth

    // idle level from another domain: taken only when stages two and three agree
    assign idle_now   = idle_stable_q;
    assign setup      = psel && !penable;
    assign depth      = crcc_depth(poly_length_minus_one_q);
    assign fifo_empty = (valid_word_count_q == 5'h00);
    assign fifo_full  = (valid_word_count_q >= depth);
    assign wr_acc     = psel && penable && pwrite;
    assign rd_acc     = psel && penable && !pwrite;
    // refusal decided in setup; pops can only free room before the access edge
    assign push       = wr_acc && (paddr == crcc_pkg::CRCC_DATA_OFS) && !pslverr;
    assign pop        = sif.word_take;
    assign run        = shifter_launch_q && !(idle_halt_select_q && idle_now);
    assign sif.run        = run;
    assign sif.word_valid = !fifo_empty;
    assign sif.word       = mem_q[rd_q];

    always_comb begin
        mem_d                   = mem_q;
        rd_d                    = rd_q;
        wr_d                    = wr_q;
        valid_word_count_d      = valid_word_count_q;
        poly_length_minus_one_d = poly_length_minus_one_q;
        idle_halt_select_d      = idle_halt_select_q;
        shifter_launch_d        = shifter_launch_q;
        mk_d                    = mk_q;
        st_d                    = st_q;
        idle_stable_d           = idle_stable_q;
        prdata_d                = 32'h0000_0000;
        pslverr_d               = 1'b0;
        if (push) begin
            mem_d[wr_q] = pwdata[15:0];
            // pointers wrap at full storage so a depth change keeps held words
            wr_d        = wr_q + 4'h1;
        end
        if (pop) begin
            rd_d = rd_q + 4'h1;
        end
        if (idle_sync_q[2] == idle_sync_q[1]) begin
            idle_stable_d = idle_sync_q[2];
        end
        valid_word_count_d = valid_word_count_q + 5'(push) - 5'(pop);
        // launch clears once the fifo is drained and the shifter idles
        if (shifter_launch_q && fifo_empty && !sif.busy && !push) begin
            shifter_launch_d = 1'b0;
        end
        if (wr_acc) begin
            case (paddr)
                crcc_pkg::CRCC_CTRL_OFS: begin
                    poly_length_minus_one_d = pwdata[crcc_pkg::CRCC_PLEN_LSB +: 4];
                    if (pwdata[crcc_pkg::CRCC_GO_BIT]) begin
                        shifter_launch_d = 1'b1;
                    end
                    idle_halt_select_d = pwdata[crcc_pkg::CRCC_IDLE_BIT];
                end
                crcc_pkg::CRCC_IRQ_MK_OFS: mk_d = pwdata[2:0];
                default:                   ;
            endcase
        end
        // read data and error decided in setup so they stand with pready
        if (setup) begin
            case (paddr)
                crcc_pkg::CRCC_CTRL_OFS,
                crcc_pkg::CRCC_IRQ_ST_OFS,
                crcc_pkg::CRCC_IRQ_MK_OFS: ;
                crcc_pkg::CRCC_DATA_OFS:   pslverr_d = pwrite && fifo_full;
                default:                   pslverr_d = 1'b1;
            endcase
        end
        // only the bits actually returned are cleared
        if (rd_acc && paddr == crcc_pkg::CRCC_IRQ_ST_OFS) begin
            st_d = st_q & ~prdata[2:0];
        end
        if (setup && !pwrite) begin
            case (paddr)
                crcc_pkg::CRCC_CTRL_OFS: begin
                    prdata_d[crcc_pkg::CRCC_PLEN_LSB +: 4] = poly_length_minus_one_q;
                    prdata_d[crcc_pkg::CRCC_GO_BIT]        = shifter_launch_q;
                    prdata_d[crcc_pkg::CRCC_EMPTY_BIT]     = fifo_empty;
                    prdata_d[crcc_pkg::CRCC_FULL_BIT]      = fifo_full;
                    prdata_d[crcc_pkg::CRCC_VW_LSB +: 5]   = valid_word_count_q;
                    prdata_d[crcc_pkg::CRCC_IDLE_BIT]      = idle_halt_select_q;
                end
                crcc_pkg::CRCC_IRQ_ST_OFS: prdata_d[2:0] = st_q;
                crcc_pkg::CRCC_IRQ_MK_OFS: prdata_d[2:0] = mk_q;
                default:                   ;
            endcase
        end
        // events set after the read clear, so set wins
        if (valid_word_count_d == 5'h00 && valid_word_count_q != 5'h00) begin
            st_d[crcc_pkg::CRCC_IRQ_EMPTY] = 1'b1;
        end
        if (push && valid_word_count_d >= depth) begin
            st_d[crcc_pkg::CRCC_IRQ_FULL] = 1'b1;
        end
        if (sif.done) begin
            st_d[crcc_pkg::CRCC_IRQ_DONE] = 1'b1;
        end
        irq_d    = |(st_d & mk_d);
        pready_d = psel && !penable;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= 16'h0000;
            end
            rd_q                    <= 4'h0;
            wr_q                    <= 4'h0;
            valid_word_count_q      <= 5'h00;
            poly_length_minus_one_q <= crcc_pkg::CRCC_PLEN_RST;
            idle_halt_select_q      <= 1'b0;
            shifter_launch_q        <= 1'b0;
            st_q                    <= 3'h0;
            mk_q                    <= 3'h0;
            idle_sync_q             <= 3'h0;
            idle_stable_q           <= 1'b0;
            prdata                  <= 32'h0000_0000;
            pslverr                 <= 1'b0;
            pready                  <= 1'b0;
            irq                     <= 1'b0;
        end else begin
            mem_q                   <= mem_d;
            rd_q                    <= rd_d;
            wr_q                    <= wr_d;
            valid_word_count_q      <= valid_word_count_d;
            poly_length_minus_one_q <= poly_length_minus_one_d;
            idle_halt_select_q      <= idle_halt_select_d;
            shifter_launch_q        <= shifter_launch_d;
            st_q                    <= st_d;
            mk_q                    <= mk_d;
            idle_sync_q             <= {idle_sync_q[1:0], idle_mode_in};
            idle_stable_q           <= idle_stable_d;
            prdata                  <= prdata_d;
            pslverr                 <= pslverr_d;
            pready                  <= pready_d;
            irq                     <= irq_d;
        end
    end

    property p_count_cap;
        @(posedge pclk) disable iff (!presetn) valid_word_count_q <= crcc_pkg::CRCC_DEPTH_NARR;
    endproperty
    a_count_cap: assert property (p_count_cap) else $error("count over 16");
    property p_empty;
        @(posedge pclk) disable iff (!presetn)
            setup && !pwrite && paddr == crcc_pkg::CRCC_CTRL_OFS && valid_word_count_q == 5'h00
            |=> prdata[crcc_pkg::CRCC_EMPTY_BIT] && !prdata[crcc_pkg::CRCC_FULL_BIT];
    endproperty
    a_empty: assert property (p_empty) else $error("empty flag wrong");
    property p_go;
        @(posedge pclk) disable iff (!presetn)
            wr_acc && paddr == crcc_pkg::CRCC_CTRL_OFS && pwdata[crcc_pkg::CRCC_GO_BIT]
            |=> shifter_launch_q;
    endproperty
    a_go: assert property (p_go) else $error("start not taken");
    property p_resv;
        @(posedge pclk) disable iff (!presetn)
            pready && !pwrite |-> prdata[15:14] == 2'h0 && prdata[5] == 1'b0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");
    property p_idle;
        @(posedge pclk) disable iff (!presetn)
            idle_halt_select_q && idle_now |-> !sif.word_take;
    endproperty
    a_idle: assert property (p_idle) else $error("word taken in idle");
    property p_ready;
        @(posedge pclk) disable iff (!presetn) psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_irq;
        @(posedge pclk) disable iff (!presetn) (|(st_q & mk_q)) |-> ##[0:1] irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_wide;
        @(posedge pclk) disable iff (!presetn)
            poly_length_minus_one_q > crcc_pkg::CRCC_WIDE_PLEN && valid_word_count_q
            == crcc_pkg::CRCC_DEPTH_WIDE |-> fifo_full;
    endproperty
    a_wide: assert property (p_wide) else $error("wide full wrong");
    c_full: cover property (@(posedge pclk) fifo_full);
    c_done: cover property (@(posedge pclk) sif.done);
    c_idle: cover property (@(posedge pclk) shifter_launch_q && !run);
endmodule : crcc_top
`default_nettype wire

// *** common/crcc_pkg.sv ***
/*
 crc control/status package: register offsets, field positions, reset values.
 assumes a 32-bit apb slave with word-aligned registers.
*/
// Contract
// - five-bit valid word count; max 8 when length above 7, else 16
// - read-only empty and full flags track the input fifo
// - writing one to start bit launches the shifter draining the fifo
// - bits 15-14 and bit 5 read zero and ignore writes
`default_nettype none
package crcc_pkg;
    localparam logic [11:0] CRCC_CTRL_OFS   = 12'h000;
    localparam logic [11:0] CRCC_DATA_OFS   = 12'h004;
    localparam logic [11:0] CRCC_IRQ_ST_OFS = 12'h008;
    localparam logic [11:0] CRCC_IRQ_MK_OFS = 12'h00C;
    localparam int          CRCC_PLEN_LSB   = 0;
    localparam int          CRCC_GO_BIT     = 4;
    localparam int          CRCC_EMPTY_BIT  = 6;
    localparam int          CRCC_FULL_BIT   = 7;
    localparam int          CRCC_VW_LSB     = 8;
    localparam int          CRCC_IDLE_BIT   = 13;
    localparam logic [3:0]  CRCC_PLEN_RST   = 4'h0;
    localparam logic [3:0]  CRCC_WIDE_PLEN  = 4'h7;
    localparam logic [4:0]  CRCC_DEPTH_WIDE = 5'h08;
    localparam logic [4:0]  CRCC_DEPTH_NARR = 5'h10;
    localparam int          CRCC_SHIFT_CYC  = 16;
    localparam int          CRCC_IRQ_EMPTY  = 0;
    localparam int          CRCC_IRQ_FULL   = 1;
    localparam int          CRCC_IRQ_DONE   = 2;
endpackage : crcc_pkg
`default_nettype wire

// *** common/crcc_shift_if.sv ***
/*
 carrier between control top and shifter.
 assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface crcc_shift_if;
    logic        word_valid;
    logic        word_take;
    logic [15:0] word;
    logic        run;
    logic        busy;
    logic        done;
    modport ctrl (output word_valid, output word, output run, input word_take,
                  input busy, input done);
    modport shft (input word_valid, input word, input run, output word_take,
                  output busy, output done);
endinterface : crcc_shift_if
`default_nettype wire

// *** rtl/crcc_shifter.sv ***
/*
 serial shifter timing: takes a word, spends a fixed count of cycles per word.
 assumes run gates progress; arithmetic is outside this block.
*/
`timescale 1ns/1ps
`default_nettype none
module crcc_shifter (
    input  wire logic  pclk,
    input  wire logic  presetn,
    crcc_shift_if.shft sif
);
    typedef enum logic [0:0] {CRCC_IDLE, CRCC_SHIFT} crcc_st_e;
    crcc_st_e   st_q, st_d;
    logic [4:0] cnt_q, cnt_d;
    logic       take_d, done_d;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        take_d = 1'b0;
        done_d = 1'b0;
        case (st_q)
            CRCC_IDLE: begin
                if (sif.run && sif.word_valid) begin
                    take_d = 1'b1;
                    cnt_d  = 5'(crcc_pkg::CRCC_SHIFT_CYC - 1);
                    st_d   = CRCC_SHIFT;
                end
            end
            CRCC_SHIFT: begin
                if (sif.run) begin
                    if (cnt_q == 5'h00) begin
                        st_d   = CRCC_IDLE;
                        done_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q - 5'h01;
                    end
                end
            end
            default: st_d = CRCC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= CRCC_IDLE;
            cnt_q <= 5'h00;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign sif.word_take = take_d;
    assign sif.done      = done_d;
    assign sif.busy      = (st_q == CRCC_SHIFT);
endmodule : crcc_shifter
`default_nettype wire

// *** tb/crcc_top_tb.sv ***
/*
 self-checking bench for the crc control/status block, random data and lengths.
 assumes a zero-wait apb slave, the register map and the irq layout below.
*/
`timescale 1ns/1ps
`default_nettype none
module crcc_top_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        idle_mode_in;
    logic        irq;
    int          num_errors;
    int          tests_run;
    logic [31:0] seed;
    logic [31:0] rd;
    logic        er;
    logic [31:0] tmp;
    logic [3:0]  plen;

    crcc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
                  .prdata(prdata), .pready(pready), .pslverr(pslverr),
                  .idle_mode_in(idle_mode_in), .irq(irq));

    always #50 pclk = ~pclk;

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function logic [4:0] depth(input logic [3:0] p);
        return (p > 4'h7) ? 5'h08 : 5'h10;
    endfunction : depth

    function logic [31:0] ctrl_e(input logic idl, input logic [4:0] c, input logic [3:0] p,
                                 input logic go);
        return {18'h0, idl, c, c == depth(p), c == 5'h00, 1'b0, go, p};
    endfunction : ctrl_e

    // junk in reserved and read-only bits must be ignored
    function logic [31:0] ctrl_w(input logic idl, input logic go, input logic [3:0] p);
        return (xs() & 32'h0000DFE0) | {18'h0, idl, 8'h00, go, p};
    endfunction : ctrl_w

    task conclude();
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rdchk

    task fill(input logic idl, input logic [3:0] p, input int first, input int last);
        for (int i = first; i < last; i++) begin
            apb(1'b1, crcc_pkg::CRCC_DATA_OFS, xs());
            check({31'h0, er}, {31'h0, i >= depth(p)});
            rdchk(crcc_pkg::CRCC_CTRL_OFS,
                  ctrl_e(idl, (i >= depth(p)) ? depth(p) : 5'(i + 1), p, 1'b0));
        end
    endtask : fill

    // polls for empty; shifter spends 17 cycles a word, one to take it and 16 shifting
    task drain();
        int n;
        n = 0;
        do begin
            apb(1'b0, crcc_pkg::CRCC_CTRL_OFS, 32'h0);
            n++;
        end while (rd[crcc_pkg::CRCC_EMPTY_BIT] !== 1'b1 && n < 400);
        if (rd[crcc_pkg::CRCC_EMPTY_BIT] !== 1'b1) begin
            num_errors++;
            conclude();
        end
        repeat (40) @(posedge pclk);
    endtask : drain

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        idle_mode_in = 1'b0;
        num_errors = 0;
        tests_run = 0;
        seed = 32'h0000_005A;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(crcc_pkg::CRCC_CTRL_OFS, ctrl_e(1'b0, 5'h00, 4'h0, 1'b0));
        tmp = xs();
        plen = {1'b1, tmp[2:0]};
        apb(1'b1, crcc_pkg::CRCC_CTRL_OFS, ctrl_w(1'b0, 1'b0, plen));
        rdchk(crcc_pkg::CRCC_CTRL_OFS, ctrl_e(1'b0, 5'h00, plen, 1'b0));
        fill(1'b0, plen, 0, 9);
        // narrow length doubles depth, count kept
        tmp = xs();
        plen = {1'b0, tmp[2:0]};
        apb(1'b1, crcc_pkg::CRCC_CTRL_OFS, ctrl_w(1'b1, 1'b0, plen));
        rdchk(crcc_pkg::CRCC_CTRL_OFS, ctrl_e(1'b1, 5'h08, plen, 1'b0));
        fill(1'b1, plen, 8, 17);
        // launch while idle: nothing may drain
        idle_mode_in <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b1, crcc_pkg::CRCC_CTRL_OFS, ctrl_w(1'b1, 1'b1, plen));
        repeat (100) @(posedge pclk);
        rdchk(crcc_pkg::CRCC_CTRL_OFS, ctrl_e(1'b1, 5'h10, plen, 1'b1));
        idle_mode_in <= 1'b0;
        drain();
        rdchk(crcc_pkg::CRCC_CTRL_OFS, ctrl_e(1'b1, 5'h00, plen, 1'b0));
        check({31'h0, irq}, 32'h0);
        rdchk(crcc_pkg::CRCC_IRQ_ST_OFS, 32'h7);
        rdchk(crcc_pkg::CRCC_IRQ_ST_OFS, 32'h0);
        // idle-halt clear: shifter keeps running in idle
        apb(1'b1, crcc_pkg::CRCC_IRQ_MK_OFS, 32'h1);
        idle_mode_in <= 1'b1;
        apb(1'b1, crcc_pkg::CRCC_CTRL_OFS, ctrl_w(1'b0, 1'b0, plen));
        apb(1'b1, crcc_pkg::CRCC_DATA_OFS, xs());
        apb(1'b1, crcc_pkg::CRCC_CTRL_OFS, ctrl_w(1'b0, 1'b1, plen));
        drain();
        rdchk(crcc_pkg::CRCC_CTRL_OFS, ctrl_e(1'b0, 5'h00, plen, 1'b0));
        check({31'h0, irq}, 32'h1);
        rdchk(crcc_pkg::CRCC_IRQ_ST_OFS, 32'h5);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check({rd[30:0], er}, 32'h1);
        conclude();
    end
endmodule : crcc_top_tb
`default_nettype wire
